// file: rtl/digitizer_output_timing.sv
// Sampling clock phase, output pipeline, port steering and sync output.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module digitizer_output_timing
    import digitizer_timing_pkg::*;
(
    input  wire logic                                     clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     hsel,
    input  wire logic [31:0]                              haddr,
    input  wire logic [1:0]                               htrans,
    input  wire logic                                     hwrite,
    input  wire logic [2:0]                               hsize,
    input  wire logic [31:0]                              hwdata,
    input  wire logic                                     hready,
    output logic      [31:0]                              hrdata,
    output logic                                          hreadyout,
    output logic                                          hresp,
    input  wire logic                                     pll_pixel_clock,
    input  wire logic                                     external_pixel_clock,
    input  wire logic                                     hsync_input,
    input  wire logic                                     sample_clock_invert,
    input  wire logic                                     power_down_n,
    input  wire logic [digitizer_timing_pkg::SAMPLE_W-1:0] converter_sample,
    output logic      [digitizer_timing_pkg::SAMPLE_W-1:0] port_a_data,
    output logic      [digitizer_timing_pkg::SAMPLE_W-1:0] port_b_data,
    output logic                                          output_data_clock,
    output logic                                          output_data_clock_n,
    output logic                                          hsync_output,
    output logic                                          outputs_oe
);

    // -------------------------------------------------------------------
    // Function
    // -------------------------------------------------------------------

    // Half of a count, used for the mid-line limit.
    function automatic logic [COUNT_W-1:0] half_of(
        input logic [COUNT_W-1:0] value
    );
        half_of = {1'b0, value[COUNT_W-1:1]};
    endfunction : half_of

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------

    logic [PHASE_W-1:0] phase_q;
    logic               order_q;
    logic               polarity_q;
    logic               dual_q;
    logic               alt_q;
    logic               ext_clock_q;

    logic               wr_pending_q;
    logic               rd_pending_q;
    logic [7:0]         addr_q;
    logic [31:0]        read_word;

    logic [4:0]         pins_sync;
    logic               pll_clock_s;
    logic               ext_clock_s;
    logic               hsync_s;
    logic               invert_s;
    logic               power_s;

    logic               pixel_clock;
    logic               sample_pulse;
    logic               fall_pulse;
    logic [COUNT_W-1:0] period;

    logic               hs_sampled_q;
    logic [COUNT_W-1:0] sample_idx_q;
    logic [COUNT_W-1:0] line_len_q;
    logic               lead_pending_q;

    logic [SAMPLE_W-1:0] pipe_data_q [PIPE_DEPTH];
    logic                pipe_even_q [PIPE_DEPTH];

    logic                dck_q;
    logic                hs_out_q;
    logic [SAMPLE_W-1:0] port_a_q;
    logic [SAMPLE_W-1:0] port_b_q;

    logic               addr_phase;
    logic               hit_ctrl;
    logic               hit_status;
    logic [31:0]        ctrl_word;
    logic [31:0]        status_word;
    logic               hs_active;
    logic               hs_lead;
    logic               hs_trail;
    logic               hs_mid_line;
    logic [COUNT_W-1:0] next_idx;
    logic               out_even;
    logic               to_port_a;
    logic               out_step;

    // -------------------------------------------------------------------
    // Register bus
    // -------------------------------------------------------------------

    assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign hit_ctrl   = (addr_q == CTRL_OFFSET);
    assign hit_status = (addr_q == STATUS_OFFSET);
    assign hreadyout  = 1'b1;
    assign hresp      = HRESP_OKAY;
    assign hrdata     = read_word;

    assign ctrl_word = {19'h00000, ext_clock_q, alt_q, dual_q, polarity_q,
                        order_q, 3'h0, phase_q};
    assign status_word = {4'h0, line_len_q, 4'h0, period};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pending_q <= 1'b0;
            rd_pending_q <= 1'b0;
            addr_q       <= 8'h00;
        end else begin
            wr_pending_q <= addr_phase & hwrite;
            rd_pending_q <= addr_phase & ~hwrite;
            if (addr_phase) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Read data follows the address latched in the address phase.
    always_comb begin
        if (hit_ctrl) begin
            read_word = ctrl_word;
        end else if (hit_status) begin
            read_word = status_word;
        end else begin
            read_word = 32'h00000000;
        end
        if (!rd_pending_q) begin
            read_word = 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q     <= PHASE_RESET;
            order_q     <= ORDER_RESET;
            polarity_q  <= POLARITY_RESET;
            dual_q      <= DUAL_RESET;
            alt_q       <= ALT_RESET;
            ext_clock_q <= EXT_RESET;
        end else if (wr_pending_q && hit_ctrl) begin
            phase_q     <= hwdata[CTRL_PHASE_LSB +: PHASE_W];
            order_q     <= hwdata[CTRL_ORDER_BIT];
            polarity_q  <= hwdata[CTRL_POLARITY_BIT];
            dual_q      <= hwdata[CTRL_DUAL_BIT];
            alt_q       <= hwdata[CTRL_ALT_BIT];
            ext_clock_q <= hwdata[CTRL_EXT_CLOCK_BIT];
        end
    end

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------

    bit_sync #(
        .WIDTH (5)
    ) pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({power_down_n, sample_clock_invert, hsync_input,
                    external_pixel_clock, pll_pixel_clock}),
        .sync_out (pins_sync)
    );

    assign pll_clock_s = pins_sync[0];
    assign ext_clock_s = pins_sync[1];
    assign hsync_s     = pins_sync[2];
    assign invert_s    = pins_sync[3];
    assign power_s     = pins_sync[4];
    assign pixel_clock = ext_clock_q ? ext_clock_s : pll_clock_s;

    // -------------------------------------------------------------------
    // Sampling clock
    // -------------------------------------------------------------------

    sample_phase_delay phase_delay (
        .clk          (clk),
        .rst_n        (rst_n),
        .pixel_clock  (pixel_clock),
        .phase        (phase_q),
        .invert       (invert_s),
        .alt_mode     (alt_q),
        .sample_pulse (sample_pulse),
        .fall_pulse   (fall_pulse),
        .period       (period)
    );

    // The data clock rises with each sampling strobe and falls half a
    // sampling period later, so both polarities track the phase setting.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dck_q <= 1'b0;
        end else if (sample_pulse) begin
            dck_q <= 1'b1;
        end else if (fall_pulse) begin
            dck_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Sync retiming and sample numbering
    // -------------------------------------------------------------------

    // Polarity select high means the incoming sync is active high.
    assign hs_active = polarity_q ? hsync_s : ~hsync_s;
    assign hs_lead   = sample_pulse & hs_active & ~hs_sampled_q;
    assign hs_trail  = ~hs_sampled_q;
    assign next_idx  = (sample_idx_q != '1)
                     ? sample_idx_q + COUNT_W'(1) : sample_idx_q;
    assign hs_mid_line = (sample_idx_q >= half_of(line_len_q));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_sampled_q <= 1'b0;
            sample_idx_q <= '0;
            line_len_q   <= '0;
        end else if (sample_pulse) begin
            hs_sampled_q <= hs_active;
            if (hs_lead) begin
                // The first sample after the leading edge is number one.
                sample_idx_q <= COUNT_W'(1);
                line_len_q   <= sample_idx_q;
            end else begin
                sample_idx_q <= next_idx;
            end
        end
    end

    // -------------------------------------------------------------------
    // Conversion pipeline
    // -------------------------------------------------------------------

    // In alternate mode the strobe only falls on the chosen pixel parity,
    // so one frame holds even columns and the next the odd ones.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_data_q[i] <= '0;
                pipe_even_q[i] <= 1'b0;
            end
        end else if (sample_pulse) begin
            pipe_data_q[0] <= converter_sample;
            pipe_even_q[0] <= hs_lead ? 1'b0 : ~next_idx[0];
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                pipe_data_q[i] <= pipe_data_q[i-1];
                pipe_even_q[i] <= pipe_even_q[i-1];
            end
        end
    end

    // -------------------------------------------------------------------
    // Output ports
    // -------------------------------------------------------------------

    assign out_even  = pipe_even_q[PIPE_DEPTH-1];
    assign to_port_a = out_even ^ order_q;
    // A strobe on the falling cycle keeps the data clock high, so nothing
    // moves then; one sample is skipped across such a phase jump.
    assign out_step  = fall_pulse & ~sample_pulse;

    // The last stage moves out at the falling data clock edge, which
    // gives five and a half sampling cycles from sample to pins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_q <= '0;
            port_b_q <= '0;
        end else if (out_step) begin
            if (!dual_q) begin
                port_a_q <= pipe_data_q[PIPE_DEPTH-1];
            end else if (to_port_a) begin
                port_a_q <= pipe_data_q[PIPE_DEPTH-1];
            end else begin
                port_b_q <= pipe_data_q[PIPE_DEPTH-1];
            end
        end
    end

    // -------------------------------------------------------------------
    // Outgoing sync
    // -------------------------------------------------------------------

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lead_pending_q <= 1'b0;
        end else if (hs_lead) begin
            lead_pending_q <= 1'b1;
        end else if (out_step) begin
            lead_pending_q <= 1'b0;
        end
    end

    // The pulse is active high and changes only with the data.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_out_q <= 1'b0;
        end else if (out_step) begin
            if (lead_pending_q) begin
                hs_out_q <= 1'b1;
            end else if (hs_trail || hs_mid_line) begin
                hs_out_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------

    assign port_a_data         = port_a_q;
    assign port_b_data         = port_b_q;
    assign output_data_clock   = dck_q;
    assign output_data_clock_n = ~dck_q;
    assign hsync_output        = hs_out_q;
    assign outputs_oe          = power_s;

endmodule : digitizer_output_timing

// file: rtl/digitizer_timing_pkg.sv
// Constants shared by the digitizer sample and output timing design.
package digitizer_timing_pkg;

    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int PHASE_W   = 5;
    localparam int COUNT_W   = 12;
    localparam int SAMPLE_W  = 24;
    localparam int PIPE_DEPTH = 6;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // -------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------
    localparam int CTRL_PHASE_LSB       = 0;
    localparam int CTRL_ORDER_BIT       = 8;
    localparam int CTRL_POLARITY_BIT    = 9;
    localparam int CTRL_DUAL_BIT        = 10;
    localparam int CTRL_ALT_BIT         = 11;
    localparam int CTRL_EXT_CLOCK_BIT   = 12;

    // -------------------------------------------------------------------
    // Status register fields
    // -------------------------------------------------------------------
    localparam int STATUS_PERIOD_LSB = 0;
    localparam int STATUS_LINE_LSB   = 16;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [PHASE_W-1:0] PHASE_RESET    = 5'h00;
    localparam logic               ORDER_RESET    = 1'b0;
    localparam logic               POLARITY_RESET = 1'b0;
    localparam logic               DUAL_RESET     = 1'b0;
    localparam logic               ALT_RESET      = 1'b0;
    localparam logic               EXT_RESET      = 1'b0;

    // -------------------------------------------------------------------
    // AHB-Lite encodings
    // -------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage : digitizer_timing_pkg

// file: rtl/bit_sync.sv
// Two flip-flop synchroniser for a group of independent level inputs.
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : bit_sync

// file: rtl/sample_phase_delay.sv
// Measures the pixel clock period and produces the delayed sampling strobes.
`timescale 1ns/1ps
module sample_phase_delay
    import digitizer_timing_pkg::*;
(
    input  wire logic                                    clk,
    input  wire logic                                    rst_n,
    input  wire logic                                    pixel_clock,
    input  wire logic [digitizer_timing_pkg::PHASE_W-1:0] phase,
    input  wire logic                                    invert,
    input  wire logic                                    alt_mode,
    output logic                                         sample_pulse,
    output logic                                         fall_pulse,
    output logic      [digitizer_timing_pkg::COUNT_W-1:0] period
);

    logic               pix_q;
    logic [COUNT_W-1:0] cnt_q;
    logic [COUNT_W-1:0] period_q;
    logic               parity_q;
    logic               seen_q;
    logic [COUNT_W-1:0] dly_q;
    logic               armed_q;
    logic [COUNT_W-1:0] fall_q;
    logic               fall_armed_q;

    logic                       pix_rise;
    logic                       accept;
    logic [COUNT_W+PHASE_W-1:0] product;
    logic [COUNT_W:0]           raw_offset;
    logic [COUNT_W-1:0]         offset;
    logic [COUNT_W-1:0]         sck_half;

    assign pix_rise = pixel_clock & ~pix_q;
    // In alternate mode only every second edge is used; the invert input
    // picks which one, a half cycle of the halved sampling clock. No strobe
    // is made before a whole pixel period has been measured.
    assign accept   = pix_rise & (period_q != '0)
                    & (~alt_mode | (parity_q == invert));
    // Each phase step is one thirty-second of the pixel period.
    assign product  = period_q * phase;
    assign raw_offset = {1'b0, product[COUNT_W+PHASE_W-1:PHASE_W]}
                      + ((invert & ~alt_mode) ? {2'b00, period_q[COUNT_W-1:1]}
                                              : '0);
    assign offset   = (raw_offset >= {1'b0, period_q})
                    ? COUNT_W'(raw_offset - {1'b0, period_q})
                    : raw_offset[COUNT_W-1:0];
    assign sck_half = alt_mode ? period_q : {1'b0, period_q[COUNT_W-1:1]};
    assign sample_pulse = armed_q & (dly_q == offset);
    assign fall_pulse   = fall_armed_q & (fall_q == '0);
    assign period       = period_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_q    <= 1'b0;
            cnt_q    <= '0;
            period_q <= '0;
            parity_q <= 1'b0;
            seen_q   <= 1'b0;
        end else begin
            pix_q <= pixel_clock;
            if (pix_rise) begin
                // The count up to the first edge is not a whole period.
                if (seen_q) begin
                    period_q <= cnt_q + COUNT_W'(1);
                end
                seen_q   <= 1'b1;
                cnt_q    <= '0;
                parity_q <= ~parity_q;
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_q   <= '0;
            armed_q <= 1'b0;
        end else if (accept) begin
            dly_q   <= '0;
            armed_q <= 1'b1;
        end else if (sample_pulse) begin
            armed_q <= 1'b0;
        end else if (armed_q) begin
            dly_q <= dly_q + COUNT_W'(1);
        end
    end

    // The falling half of the data clock lasts half a sampling period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_q       <= '0;
            fall_armed_q <= 1'b0;
        end else if (sample_pulse) begin
            fall_q       <= (sck_half > COUNT_W'(1))
                          ? sck_half - COUNT_W'(1) : '0;
            fall_armed_q <= 1'b1;
        end else if (fall_pulse) begin
            fall_armed_q <= 1'b0;
        end else if (fall_armed_q) begin
            fall_q <= fall_q - COUNT_W'(1);
        end
    end

endmodule : sample_phase_delay

// file: verification/capture_model.sv
// Downstream capture logic that samples both ports on each data clock rise after the first seven following output enable.
`timescale 1ns/1ps
module capture_model
    import digitizer_timing_pkg::*;
(
    input wire logic                                     clk,
    input wire logic                                     outputs_oe,
    input wire logic                                     output_data_clock,
    input wire logic [digitizer_timing_pkg::SAMPLE_W-1:0] port_a_data,
    input wire logic [digitizer_timing_pkg::SAMPLE_W-1:0] port_b_data
);
    logic                dclk_q = 1'b0;
    int                  skip = 7;
    logic [SAMPLE_W-1:0] cap_a[$];
    logic [SAMPLE_W-1:0] cap_b[$];
    always @(posedge clk) begin
        dclk_q <= output_data_clock;
        if (!outputs_oe) skip <= 7;
        else if (output_data_clock && !dclk_q && skip > 0) skip <= skip - 1;
        else if (output_data_clock && !dclk_q) begin
            cap_a.push_back(port_a_data);
            cap_b.push_back(port_b_data);
        end
    end
endmodule : capture_model

// file: verification/digitizer_output_timing_properties.sv
// Timing checks on the digitizer output pins.
`timescale 1ns/1ps
module digitizer_output_timing_checker
    import digitizer_timing_pkg::*;
(
    input wire logic                                     clk,
    input wire logic                                     rst_n,
    input wire logic                                     power_down_n,
    input wire logic [digitizer_timing_pkg::SAMPLE_W-1:0] port_a_data,
    input wire logic [digitizer_timing_pkg::SAMPLE_W-1:0] port_b_data,
    input wire logic                                     output_data_clock,
    input wire logic                                     output_data_clock_n,
    input wire logic                                     hsync_output,
    input wire logic                                     outputs_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_release: assert property (!power_down_n [*4] |-> !outputs_oe)
        else $error("outputs driven in power down");
    a_oe_drive: assert property (power_down_n [*4] |-> outputs_oe)
        else $error("outputs released while enabled");
    a_clock_pair: assert property (outputs_oe |->
        output_data_clock_n == !output_data_clock) else $error("clock pair");
    a_clock_high: assert property ($rose(output_data_clock) |=>
        output_data_clock [*2]) else $error("data clock high too short");
    a_clock_fall: assert property ($rose(output_data_clock) |->
        ##[2:30] !output_data_clock) else $error("data clock stuck high");
    a_port_a_edge: assert property (!$stable(port_a_data) |->
        $fell(output_data_clock)) else $error("port a changed off fall");
    a_port_b_edge: assert property (!$stable(port_b_data) |->
        $fell(output_data_clock)) else $error("port b changed off fall");
    a_sync_edge: assert property ($changed(hsync_output) |->
        $fell(output_data_clock)) else $error("sync changed off fall");
endmodule : digitizer_output_timing_checker

bind digitizer_output_timing digitizer_output_timing_checker u_checker (
    .clk(clk), .rst_n(rst_n), .power_down_n(power_down_n),
    .port_a_data(port_a_data), .port_b_data(port_b_data),
    .output_data_clock(output_data_clock),
    .output_data_clock_n(output_data_clock_n),
    .hsync_output(hsync_output), .outputs_oe(outputs_oe));

// file: verification/video_digitizer_sample_output_timing_bench.sv
// Self-checking bench for the digitizer output timing block.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module video_digitizer_sample_output_timing_bench;
    import digitizer_timing_pkg::*;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, pix = 0, pix_q = 0;
    logic hs_in = 1, inv = 0, pd_n = 1, dclk_q = 0, hreadyout, hresp;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
    logic [SAMPLE_W-1:0] conv = 0, nv, pa, pb, sent[$];
    logic dclk, dclk_n, hs_out, oe;
    int miscompares = 0, samples_checked = 0, cycles = 0, pcnt = 0, hs_w = 4;
    int pt = 0, dt = 0, dly = 0, dper = 0, hs_len = 0, last_len = 0;
    int ka, kb, d0, par, lat;
    digitizer_output_timing DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pll_pixel_clock(pix),
        .external_pixel_clock(pix), .hsync_input(hs_in),
        .sample_clock_invert(inv), .power_down_n(pd_n),
        .converter_sample(conv), .port_a_data(pa), .port_b_data(pb),
        .output_data_clock(dclk), .output_data_clock_n(dclk_n),
        .hsync_output(hs_out), .outputs_oe(oe));
    capture_model cm (.clk(clk), .outputs_oe(oe), .output_data_clock(dclk),
        .port_a_data(pa), .port_b_data(pb));
    initial forever #2.5 clk = ~clk;
    initial begin
        #3.7;
        forever #24 pix = ~pix;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        pix_q <= pix;
        dclk_q <= dclk;
        hs_len <= hs_out ? hs_len + 1 : 0;
        if (!hs_out && hs_len > 0) last_len <= hs_len;
        if (dclk && !dclk_q) dly <= cycles - pt;
        if (dclk && !dclk_q) dper <= cycles - dt;
        if (dclk && !dclk_q) dt <= cycles;
        if (dclk && !dclk_q) lat <= sent.size() - 1 - find(pa);
        if (pix && !pix_q) begin
            nv = SAMPLE_W'($urandom);
            sent.push_back(nv);
            conv <= nv;
            pt <= cycles;
            pcnt <= (pcnt == 39) ? 0 : pcnt + 1;
            hs_in <= !(pcnt < hs_w);
        end
        if (cycles == 30000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask : bus
    task automatic cfg(input logic [31:0] c);
        bus(1'b1, CTRL_OFFSET, c);
        repeat (300) @(posedge clk);
    endtask : cfg
    function automatic int find(input logic [SAMPLE_W-1:0] v);
        foreach (sent[j]) if (sent[j] === v) return j;
        return -1000;
    endfunction : find
    task automatic stream(input logic [31:0] c, input int st, input int dv);
        int s;
        cfg(c);
        cm.cap_a.delete();
        cm.cap_b.delete();
        repeat (400) @(posedge clk);
        `CHK(cm.cap_a.size() > 15, 1'b1)
        ka = find(cm.cap_a[0]);
        kb = find(cm.cap_b[0]);
        foreach (cm.cap_a[i]) begin
            s = (dv == 2 && kb > ka ? kb : ka) + i * st;
            `CHK(cm.cap_a[i], sent[s - (s - ka) % dv])
            if (dv == 2) `CHK(cm.cap_b[i], sent[s - (s - kb) % dv])
        end
    endtask : stream
    task automatic complete_run;
        $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(4));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, CTRL_OFFSET, 0);
        `CHK(rd, 32'h0)
        bus(1'b0, 8'h08, 0);
        `CHK(rd, 32'h0)
        bus(1'b1, CTRL_OFFSET, 32'h0000_1F1F);
        bus(1'b0, CTRL_OFFSET, 0);
        `CHK(rd, 32'h0000_1F1F)
        cfg(32'h0);
        bus(1'b0, STATUS_OFFSET, 0);
        `CHK(rd[11:0] inside {12'h009, 12'h00A}, 1'b1)
        d0 = dly;
        cfg(32'h10);
        `CHK((dly - d0) inside {[3:6]}, 1'b1)
        cfg(32'h0);
        inv <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK((dly - d0) inside {[3:6]}, 1'b1)
        inv <= 1'b0;
        stream(32'h0, 1, 1);
        `CHK(lat, 6)
        stream(32'h400, 1, 2);
        `CHK((ka - kb) % 2 != 0, 1'b1)
        par = ka % 2;
        stream(32'h500, 1, 2);
        `CHK(ka % 2, 1 - par)
        stream(32'h800, 2, 1);
        `CHK(dper inside {[18:21]}, 1'b1)
        par = ka % 2;
        inv <= 1'b1;
        stream(32'h800, 2, 1);
        `CHK(ka % 2, 1 - par)
        inv <= 1'b0;
        cfg(32'h0);
        repeat (1500) @(posedge clk);
        `CHK(last_len inside {[28:50]}, 1'b1)
        hs_w = 30;
        repeat (1500) @(posedge clk);
        `CHK(last_len inside {[150:230]}, 1'b1)
        hs_w = 4;
        cfg(32'h200);
        repeat (1500) @(posedge clk);
        `CHK(last_len inside {[150:230]}, 1'b1)
        pd_n <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(oe, 1'b0)
        pd_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(oe, 1'b1)
        complete_run();
    end
endmodule : video_digitizer_sample_output_timing_bench
